// [rtl/bcpt_chan_out.sv]
/*
 * One compare channel: match detection and pin action.
 * Assumes the core drives counter, events and controls on this clock.
 */
`timescale 1ns/1ps
module bcpt_chan_out
    import bcpt_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst_n,
    input  wire logic  ce,
    // Core link
    bcpt_chan_if.chan  ch
);
    logic             pin_q;
    logic             pin_d;
    logic             wrapped;
    logic [CNT_W-1:0] next_cnt;

    // Match when the counter becomes the compare value, so 128 of 256 is half duty
    assign next_cnt     = ch.wrap_evt ? '0 : ch.count + CNT_W'(1);
    assign ch.match_evt = ch.enable_oc & ch.tick & (next_cnt == ch.compare_val); // RULE9
    assign ch.pin       = pin_q;

    always_comb
    begin
        wrapped = ch.wrap_evt & ch.enable_oc & ch.toggle_on_wrap ? ~pin_q : pin_q; // RULE5
        pin_d   = wrapped;
        if (ch.full_duty_select & ch.toggle_on_wrap)
        begin
            pin_d = 1'b1; // RULE15
        end
        else if (ch.match_evt)
        begin
            unique case (ch.edge_sel)
                EDGE_TOGGLE: pin_d = ~wrapped;
                EDGE_CLEAR:  pin_d = 1'b0; // RULE14
                EDGE_SET:    pin_d = 1'b1;
                default:     pin_d = wrapped;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pin_q <= 1'b0;
        end
        else if (ce)
        begin
            pin_q <= pin_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_full_duty;
        @(posedge clock) disable iff (!rst_n)
        ce & ch.full_duty_select & ch.toggle_on_wrap |=> pin_q;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty not high"); // RULE15

    property p_zero_duty;
        @(posedge clock) disable iff (!rst_n)
        ce & ~ch.toggle_on_wrap & ~ch.full_duty_select & (ch.edge_sel == EDGE_CLEAR) & ~pin_q
        |=> ~pin_q;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty output rose"); // RULE14

    property p_wrap_toggle;
        @(posedge clock) disable iff (!rst_n)
        ce & ch.wrap_evt & ch.enable_oc & ch.toggle_on_wrap & ~ch.full_duty_select
        & ~ch.match_evt |=> pin_q != $past(pin_q);
    endproperty
    a_wrap_toggle: assert property (p_wrap_toggle) else $error("no toggle on wrap"); // RULE5
endmodule

// [rtl/bcpt_prescaler.sv]
/*
 * Bus clock prescaler producing the counter advance strobe.
 * Assumes halt and select come from registers and clear from a bus write decode, on the same clock.
 */
`timescale 1ns/1ps
module bcpt_prescaler
    import bcpt_pkg::*;
(
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            ce,
    // Control
    input  wire logic            halt,
    input  wire logic            clear,
    input  wire logic [PS_W-1:0] sel,
    // Advance strobe
    output logic                 tick
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;

    assign mask = DIV_W'((7'h01 << sel) - 7'h01);
    assign tick = ~halt & ~clear & (sel != PS_UNUSED) & ((div_q & mask) == mask); // RULE20

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            div_q <= '0;
        end
        else if (ce)
        begin
            if (clear)
            begin
                div_q <= '0; // RULE18
            end
            else if (!halt)
            begin
                div_q <= div_q + DIV_W'(1);
            end
        end
    end
endmodule

// [rtl/bcpt_top.sv]
/*
 * Buffered compare PWM timer: 16-bit counter, two compare channels,
 * buffered pair linking, Avalon-MM register slave.
 * Assumes a bus master on the same clock; pins resolved outside.
 */
// Summary of operation
// RULE1: Link bit merges channels onto channel 0 pin
// RULE2: Buffered pair swaps to last written at wrap
// RULE3: Linked: channel 0 control rules, channel 1 ignored
// RULE4: Software writes only the inactive pair
// RULE5: Toggle pin when counter reaches period limit
// RULE6: Software picks clear or set compare polarity
// RULE7: Limit 255, divide one gives 256 cycles
// RULE8: Compare 128 of 256 gives half duty
// RULE9: Passed new compare value skips that period
// RULE10: Software times unbuffered updates by interrupts
// RULE11: Software avoids toggle on compare for PWM
// RULE12: Software follows halt, clear, program, release order
// RULE13: Link bit overrides channel 0 low mode
// RULE14: No wrap toggle and clear gives zero duty
// RULE15: Full duty plus wrap toggle holds high
// RULE16: Wrap flag sets; enabled flag raises request
// RULE17: Channel event sets flag; enabled raises request
// RULE18: Clear bit zeroes counter, prescaler, reads zero
// RULE19: Reset halts counter until software releases
// RULE20: Divide select one to sixty-four, seven unused
// RULE21: After limit counter restarts from zero
// RULE22: Sixteen-bit counter and compare values
`timescale 1ns/1ps
module bcpt_top
    import bcpt_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               ce,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]  address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    input  wire logic [3:0]         byteenable,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    // Channel pins
    output logic                    chan0_pin_out,
    output logic                    chan0_pin_oe,
    output logic                    chan1_pin_out,
    output logic                    chan1_pin_oe,
    // Interrupt request
    output logic                    irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic                 ack_q;
    logic [31:0]          readdata_q;
    logic                 halt_q;
    logic                 wrap_ie_q;
    logic [PS_W-1:0]      ps_q;
    logic                 wrap_flag_q;
    logic                 wrap_arm_q;
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     period_q;
    logic [CH_CTL_W-1:0]  ctl_q  [NUM_CH];
    logic                 flag_q [NUM_CH];
    logic                 arm_q  [NUM_CH];
    logic [CNT_W-1:0]     val_q  [NUM_CH];
    logic                 last_q;
    logic                 active_q;

    logic                 wr_go;
    logic                 rd_go;
    logic                 tsc_wr;
    logic                 clr_go;
    logic                 tick;
    logic                 wrap_evt;
    logic                 link;
    logic                 match [NUM_CH];
    logic                 pin   [NUM_CH];
    logic [31:0]          rd_mux;

    bcpt_chan_if          chif [NUM_CH] ();

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_go       = ce & write & ack_q;
    assign rd_go       = ce & read & ack_q;
    assign tsc_wr      = wr_go & (address == REG_TSC);
    assign clr_go      = tsc_wr & writedata[TSC_CLEAR];
    assign readdata    = readdata_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else if (ce)
        begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    always_comb
    begin
        unique case (address)
            REG_TSC:
            begin
                rd_mux = {24'h000000, wrap_flag_q, wrap_ie_q, halt_q, 1'b0, 1'b0, ps_q}; // RULE18
            end
            REG_COUNT:     rd_mux = {16'h0000, cnt_q};
            REG_PERIOD:    rd_mux = {16'h0000, period_q};
            REG_CH0_CTL:   rd_mux = {24'h000000, flag_q[0], ctl_q[0]};
            REG_CH0_VAL:   rd_mux = {16'h0000, val_q[0]};
            REG_CH1_CTL:   rd_mux = {24'h000000, flag_q[1], ctl_q[1]};
            REG_CH1_VAL:   rd_mux = {16'h0000, val_q[1]};
            REG_PIN_STATE: rd_mux = {29'h00000000, active_q, pin[1], pin[0]};
            default:       rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            readdata_q <= 32'h00000000;
        end
        else if (ce & read & ~ack_q)
        begin
            readdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Timer control register
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            halt_q    <= 1'b1; // RULE19
            wrap_ie_q <= 1'b0;
            ps_q      <= PS_RESET;
        end
        else if (tsc_wr)
        begin
            halt_q    <= writedata[TSC_HALT];
            wrap_ie_q <= writedata[TSC_WRAP_IE];
            ps_q      <= writedata[TSC_PS_LSB +: PS_W];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            period_q <= PERIOD_RESET;
        end
        else if (wr_go & (address == REG_PERIOD))
        begin
            period_q <= bcpt_merge16(period_q, writedata, byteenable);
        end
    end

    // Wrap flag: read while set arms, write 0 clears, a new wrap wins
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wrap_flag_q <= 1'b0;
            wrap_arm_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (wrap_evt)
            begin
                wrap_flag_q <= 1'b1; // RULE16
                wrap_arm_q  <= 1'b0;
            end
            else if (tsc_wr & wrap_arm_q & ~writedata[TSC_WRAP_FLAG])
            begin
                wrap_flag_q <= 1'b0;
                wrap_arm_q  <= 1'b0;
            end
            else if (rd_go & (address == REG_TSC) & wrap_flag_q)
            begin
                wrap_arm_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    bcpt_prescaler u_prescaler (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .halt  (halt_q),
        .clear (clr_go),
        .sel   (ps_q),
        .tick  (tick)
    );

    assign wrap_evt = tick & (cnt_q == period_q); // RULE7

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
        end
        else if (ce)
        begin
            if (clr_go)
            begin
                cnt_q <= '0; // RULE18
            end
            else if (wrap_evt)
            begin
                cnt_q <= '0; // RULE21
            end
            else if (tick)
            begin
                cnt_q <= cnt_q + CNT_W'(1); // RULE22
            end
        end
    end

    // ----------------------------------------------------------------
    // Buffered pair selection
    // ----------------------------------------------------------------
    assign link = ctl_q[0][CH_MODE_HI]; // RULE13

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            last_q   <= 1'b0;
            active_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_go & (address == REG_CH0_VAL))
            begin
                last_q <= 1'b0;
            end
            else if (wr_go & (address == REG_CH1_VAL))
            begin
                last_q <= 1'b1;
            end
            if (!link)
            begin
                active_q <= 1'b0;
            end
            else if (wrap_evt)
            begin
                active_q <= last_q; // RULE2
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        localparam logic [4:0] CTL_A = (i == 0) ? REG_CH0_CTL : REG_CH1_CTL;
        localparam logic [4:0] VAL_A = (i == 0) ? REG_CH0_VAL : REG_CH1_VAL;
        logic ctl_wr;
        logic mode_on;

        assign ctl_wr  = wr_go & (address == CTL_A);
        assign mode_on = (i == 0) ? (link | ctl_q[0][CH_MODE_LO])
                                  : (~link & (ctl_q[1][CH_MODE_HI] | ctl_q[1][CH_MODE_LO])); // RULE3

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                ctl_q[i] <= CH_CTL_RESET;
                val_q[i] <= VAL_RESET;
            end
            else if (ce)
            begin
                if (ctl_wr)
                begin
                    ctl_q[i] <= writedata[CH_CTL_W-1:0];
                end
                if (wr_go & (address == VAL_A))
                begin
                    val_q[i] <= bcpt_merge16(val_q[i], writedata, byteenable);
                end
            end
        end

        // Channel flag with the same arm-and-clear sequence as the wrap flag
        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                flag_q[i] <= 1'b0;
                arm_q[i]  <= 1'b0;
            end
            else if (ce)
            begin
                if (match[i])
                begin
                    flag_q[i] <= 1'b1; // RULE17
                    arm_q[i]  <= 1'b0;
                end
                else if (ctl_wr & arm_q[i] & ~writedata[CH_FLAG])
                begin
                    flag_q[i] <= 1'b0;
                    arm_q[i]  <= 1'b0;
                end
                else if (rd_go & (address == CTL_A) & flag_q[i])
                begin
                    arm_q[i] <= 1'b1;
                end
            end
        end

        assign chif[i].tick             = tick;
        assign chif[i].count            = cnt_q;
        assign chif[i].wrap_evt         = wrap_evt;
        assign chif[i].compare_val      = (i == 0 && link && active_q) ? val_q[1] : val_q[i]; // RULE8
        assign chif[i].enable_oc        = mode_on;
        assign chif[i].edge_sel         = {ctl_q[i][CH_EDGE_HI], ctl_q[i][CH_EDGE_LO]};
        assign chif[i].toggle_on_wrap   = ctl_q[i][CH_TOV];
        assign chif[i].full_duty_select = ctl_q[i][CH_FULL];
        assign match[i]                 = chif[i].match_evt;
        assign pin[i]                   = chif[i].pin;

        bcpt_chan_out u_chan (
            .clock (clock),
            .rst_n (rst_n),
            .ce    (ce),
            .ch    (chif[i])
        );
    end

    // ----------------------------------------------------------------
    // Pins and request
    // ----------------------------------------------------------------
    assign chan0_pin_out = pin[0];
    assign chan0_pin_oe  = g_ch[0].mode_on; // RULE1
    assign chan1_pin_out = pin[1];
    assign chan1_pin_oe  = g_ch[1].mode_on; // RULE1
    assign irq = (wrap_flag_q & wrap_ie_q) | (flag_q[0] & ctl_q[0][CH_IE])
               | (flag_q[1] & ctl_q[1][CH_IE]); // RULE16

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_link_release;
        link |-> ~chan1_pin_oe & chan0_pin_oe;
    endproperty
    a_link_release: assert property (p_link_release) else $error("link pin ownership"); // RULE1

    property p_buffer_swap;
        ce & link & wrap_evt |=> active_q == $past(last_q);
    endproperty
    a_buffer_swap: assert property (p_buffer_swap) else $error("pair not swapped"); // RULE2

    property p_chan1_idle;
        link |-> ~match[1];
    endproperty
    a_chan1_idle: assert property (p_chan1_idle) else $error("channel 1 active"); // RULE3

    property p_halt_freeze;
        ce & halt_q & ~clr_go |=> $stable(cnt_q);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("halted counter moved"); // RULE19

    property p_clear;
        clr_go |=> (cnt_q == '0) && (u_prescaler.div_q == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear bit failed"); // RULE18

    property p_restart;
        ce & wrap_evt |=> (cnt_q == '0) && wrap_flag_q;
    endproperty
    a_restart: assert property (p_restart) else $error("wrap not handled"); // RULE21

    property p_wrap_irq;
        wrap_flag_q & wrap_ie_q |-> irq;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) else $error("wrap request missing"); // RULE16

    property p_chan_flag;
        ce & match[0] |=> flag_q[0] && (!ctl_q[0][CH_IE] || irq);
    endproperty
    a_chan_flag: assert property (p_chan_flag) else $error("channel flag missing"); // RULE17

    property p_unused_ps;
        ps_q == PS_UNUSED |-> ~tick;
    endproperty
    a_unused_ps: assert property (p_unused_ps) else $error("unused divide ticked"); // RULE20

    property p_div_one;
        ce & ~halt_q & (ps_q == PS_RESET) & ~clr_go & (cnt_q != period_q)
        |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide one stalled"); // RULE7

    c_wrap:      cover property (wrap_evt ##[1:300] wrap_evt);
    c_swap:      cover property (link & wrap_evt & last_q ##1 active_q);
    c_full_duty: cover property (ctl_q[0][CH_FULL] & ctl_q[0][CH_TOV] & chan0_pin_out);
    c_flag_clr:  cover property (wrap_flag_q ##1 ~wrap_flag_q);
endmodule

// [shared/bcpt_chan_if.sv]
/*
 * Link between the timer core and one compare output channel.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface bcpt_chan_if;
    import bcpt_pkg::*;
    logic              tick;
    logic [CNT_W-1:0]  count;
    logic              wrap_evt;
    logic [CNT_W-1:0]  compare_val;
    logic              enable_oc;
    logic [1:0]        edge_sel;
    logic              toggle_on_wrap;
    logic              full_duty_select;
    logic              match_evt;
    logic              pin;

    modport timer (output tick, count, wrap_evt, compare_val, enable_oc, edge_sel,
                   toggle_on_wrap, full_duty_select, input match_evt, pin);
    modport chan  (input tick, count, wrap_evt, compare_val, enable_oc, edge_sel,
                   toggle_on_wrap, full_duty_select, output match_evt, pin);
endinterface

// [shared/bcpt_pkg.sv]
/*
 * Constants, register map and byte-merge helper for the buffered
 * compare PWM timer.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package bcpt_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  REG_TSC       = 5'h00;
    localparam logic [4:0]  REG_COUNT     = 5'h04;
    localparam logic [4:0]  REG_PERIOD    = 5'h08;
    localparam logic [4:0]  REG_CH0_CTL   = 5'h0c;
    localparam logic [4:0]  REG_CH0_VAL   = 5'h10;
    localparam logic [4:0]  REG_CH1_CTL   = 5'h14;
    localparam logic [4:0]  REG_CH1_VAL   = 5'h18;
    localparam logic [4:0]  REG_PIN_STATE = 5'h1c;

    // ----------------------------------------------------------------
    // Timer status and control fields
    // ----------------------------------------------------------------
    localparam int TSC_WRAP_FLAG = 7;
    localparam int TSC_WRAP_IE   = 6;
    localparam int TSC_HALT      = 5;
    localparam int TSC_CLEAR     = 4;
    localparam int TSC_PS_LSB    = 0;
    localparam int PS_W          = 3;

    // ----------------------------------------------------------------
    // Channel status and control fields
    // ----------------------------------------------------------------
    localparam int CH_FLAG     = 7;
    localparam int CH_IE       = 6;
    localparam int CH_MODE_HI  = 5;
    localparam int CH_MODE_LO  = 4;
    localparam int CH_EDGE_HI  = 3;
    localparam int CH_EDGE_LO  = 2;
    localparam int CH_TOV      = 1;
    localparam int CH_FULL     = 0;
    localparam int CH_CTL_W    = 7;

    // ----------------------------------------------------------------
    // Pin state fields, widths and reset values
    // ----------------------------------------------------------------
    localparam int PIN0_BIT    = 0;
    localparam int PIN1_BIT    = 1;
    localparam int ACTIVE_BIT  = 2;
    localparam int CNT_W       = 16;
    localparam int DIV_W       = 6;
    localparam int NUM_CH      = 2;

    localparam logic [PS_W-1:0]     PS_UNUSED      = 3'h7;
    localparam logic [CNT_W-1:0]    PERIOD_RESET   = 16'hffff;
    localparam logic [CNT_W-1:0]    VAL_RESET      = 16'h0000;
    localparam logic [CH_CTL_W-1:0] CH_CTL_RESET   = 7'h00;
    localparam logic [PS_W-1:0]     PS_RESET       = 3'h0;
    localparam logic [1:0]          EDGE_TOGGLE    = 2'h1;
    localparam logic [1:0]          EDGE_CLEAR     = 2'h2;
    localparam logic [1:0]          EDGE_SET       = 2'h3;

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [CNT_W-1:0] bcpt_merge16(
        input logic [CNT_W-1:0] old_v,
        input logic [31:0]      wdata,
        input logic [3:0]       be
    );
        logic [CNT_W-1:0] res;
        res        = old_v;
        if (be[0])
        begin
            res[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

endpackage

// [sim/bcpt_pin_load.sv]
/* Load on the channel 0 pin: measures PWM period and high time.
   Assumes a pull-down holds the pin low while it is released. */
`timescale 1ns/1ps
module bcpt_pin_load
(
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   rst_n,
    // Pin
    input  wire logic   pin_out,
    input  wire logic   pin_oe,
    // Measurements
    output logic [15:0] period_len,
    output logic [15:0] high_len
);
    logic        lvl;
    logic        lvl_q;
    logic [15:0] cnt_q;
    logic [15:0] high_q;

    assign lvl = pin_oe & pin_out;

    // ------------------------------------------------------------
    // Rising edge to rising edge
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lvl_q      <= 1'b0;
            cnt_q      <= 16'h0000;
            high_q     <= 16'h0000;
            period_len <= 16'h0000;
            high_len   <= 16'h0000;
        end
        else
        begin
            lvl_q  <= lvl;
            cnt_q  <= cnt_q + 16'h0001;
            high_q <= high_q + {15'h0000, lvl};
            if (lvl && !lvl_q)
            begin
                period_len <= cnt_q;
                high_len   <= high_q;
                cnt_q      <= 16'h0001;
                high_q     <= 16'h0001;
            end
        end
    end
endmodule

// [sim/test_buffered_compare_pwm_timer.sv]
/* Bench: Avalon-MM tasks and PWM checks on the channel 0 pin.
   Assumes the pin load model measures each period. */
`timescale 1ns/1ps
module test_buffered_compare_pwm_timer
    import bcpt_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] q;
    logic        waitrequest;
    logic        pin0;
    logic        oe0;
    logic        oe1;
    logic        pin1;
    logic        irq;
    logic [15:0] period_len;
    logic [15:0] high_len;
    int          err_total = 0;
    int          compares = 0;

    always #50 clock = ~clock;

    bcpt_top u_dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .chan0_pin_out(pin0),
        .chan0_pin_oe(oe0), .chan1_pin_out(pin1), .chan1_pin_oe(oe1), .irq(irq));
    bcpt_pin_load u_load (.clock(clock), .rst_n(rst_n), .pin_out(pin0), .pin_oe(oe0),
        .period_len(period_len), .high_len(high_len));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask

    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        do
        begin
            @(posedge clock);
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", e, q);
    endtask

    task pwm(input logic [15:0] hi);
        repeat (800) @(posedge clock);
        chk("period", 32'h100, {16'h0, period_len});
        chk("high", {16'h0, hi}, {16'h0, high_len});
    endtask

    task hold(input logic lvl);
        logic [31:0] bad;
        bad = 32'h0;
        repeat (300) @(posedge clock);
        repeat (256) @(negedge clock) if (pin0 !== lvl) bad = 32'h1;
        chk("pin_held", 32'h0, bad);
    endtask

    task end_sim;
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (10000) @(posedge clock);
        err_total++;
        end_sim;
    end

    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(REG_TSC, 32'h20);
        rd(REG_PERIOD, 32'hffff);
        rd(5'h01, 32'h0);
        bus(1'b1, REG_TSC, 32'h30);
        rd(REG_TSC, 32'h20);
        rd(REG_COUNT, 32'h0);
        bus(1'b1, REG_PERIOD, 32'hff);
        bus(1'b1, REG_CH0_VAL, 32'h80);
        bus(1'b1, REG_CH0_CTL, 32'h1a);
        bus(1'b1, REG_TSC, 32'h40);
        pwm(16'h80);
        chk("irq", 32'h1, {31'h0, irq});
        rd(REG_TSC, 32'hc0);
        rd(REG_CH0_CTL, 32'h9a);
        bus(1'b1, REG_CH0_CTL, 32'h3a);
        bus(1'b1, REG_CH1_CTL, 32'h04);
        bus(1'b1, REG_CH1_VAL, 32'h40);
        pwm(16'h40);
        chk("chan1_pin_oe", 32'h0, {31'h0, oe1});
        chk("chan1_pin_out", 32'h0, {31'h0, pin1});
        bus(1'b0, REG_PIN_STATE, 32'h0);
        chk("active_pair", 32'h1, {31'h0, q[ACTIVE_BIT]});
        bus(1'b1, REG_CH0_CTL, 32'h3b);
        hold(1'b1);
        bus(1'b1, REG_CH0_CTL, 32'h38);
        hold(1'b0);
        end_sim;
    end
endmodule
